/* File: shared/mrs_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes the five-bit page-0 register address of the serial command engine
`ifndef MRS_DEFINES_SVH
`define MRS_DEFINES_SVH

`define MRS_W 24
`define MRS_AW 5

// page-0 register offsets
`define MRS_OFF_FLAGS 5'h0f
`define MRS_OFF_I1PK 5'h12
`define MRS_OFF_V1PK 5'h13
`define MRS_OFF_S1 5'h14
`define MRS_OFF_PF1 5'h15
`define MRS_OFF_I2PK 5'h16
`define MRS_OFF_V2PK 5'h17
`define MRS_OFF_S2 5'h18
`define MRS_OFF_PF2 5'h19
`define MRS_OFF_MASK 5'h1a
`define MRS_OFF_TEMP 5'h1b
`define MRS_OFF_CTRL 5'h1c
`define MRS_OFF_EPUL 5'h1d
`define MRS_OFF_SPUL 5'h1e
`define MRS_OFF_QPUL 5'h1f

// reset values
`define MRS_FLAGS_RST 24'h000001
`define MRS_MASK_RST 24'h000000
`define MRS_CTRL_RST 24'h000000

// event flag bit positions
`define MRS_B_LOWRATE_RESULTS_READY 23
`define MRS_B_CURRENT2_OVERFLOW_FLAG 22
`define MRS_B_VOLTAGE2_OVERFLOW_FLAG 21
`define MRS_B_SAMPLE_RESULTS_READY 20
`define MRS_B_CURRENT2_RMS_OVERFLOW_FLAG 19
`define MRS_B_VOLTAGE2_RMS_OVERFLOW_FLAG 18
`define MRS_B_CURRENT1_OVERFLOW_FLAG 17
`define MRS_B_VOLTAGE1_OVERFLOW_FLAG 16
`define MRS_B_ENERGY2_OVERFLOW_FLAG 15
`define MRS_B_CURRENT1_RMS_OVERFLOW_FLAG 14
`define MRS_B_VOLTAGE1_RMS_OVERFLOW_FLAG 13
`define MRS_B_ENERGY1_OVERFLOW_FLAG 12
`define MRS_B_I1FLT 11
`define MRS_B_V1DIP 10
`define MRS_B_I2FLT 9
`define MRS_B_V2DIP 8
`define MRS_B_TUP 7
`define MRS_B_TOD 6
`define MRS_B_CURRENT2_MODULATOR_OSC_FLAG 5
`define MRS_B_VOD 4
`define MRS_B_CURRENT1_MODULATOR_OSC_FLAG 3
`define MRS_B_LSD 2
`define MRS_B_FUP 1
`define MRS_B_IC 0
// flag bits stored active high; the bad-command bit reads inverted
`define MRS_FLAGS_INV 24'h000001

// control field positions
`define MRS_C_PC_HI 23
`define MRS_C_PC_LO 16
`define MRS_C_CURRENT2_RANGE_SELECT 12
`define MRS_C_STOP 8
`define MRS_C_CURRENT1_RANGE_SELECT 5
`define MRS_C_IRQ_OPEN_DRAIN 4
`define MRS_C_HOST_CLOCK_DISABLE 2
`define MRS_C_CRYSTAL_OSC_DISABLE 1
// bits kept by a control write; the stop bit is a strobe and reads 0
`define MRS_CTRL_KEEP 24'hff1036

// fixed-point helpers
`define MRS_PF_MAX 24'h7fffff
`define MRS_PF_MIN 24'h800000
`define MRS_ZERO24 24'h000000

// interrupt pulse width
`define MRS_CLK_MHZ 250
`define MRS_IRQ_PULSE_NS 1000
`define MRS_IRQ_PULSE_CYC ((`MRS_IRQ_PULSE_NS * `MRS_CLK_MHZ + 999) / 1000)
`define MRS_CNT_W 9

`endif

/* File: shared/mrs_pkg.sv */
// types shared by the meter result, status and control register bank
// assumes mrs_defines.svh for all numbers
package mrs_pkg;

  // interrupt pin pulse sequencer
  typedef enum logic [1:0] {
    MRS_IRQ_IDLE = 2'b01,
    MRS_IRQ_PULSE = 2'b10
  } mrs_irq_state_t;

endpackage

/* File: hdl/mrs_regs.sv */
// page-0 result, event flag, interrupt mask and control registers
// assumes a same-clock serial command engine and measurement datapath;
// comparator levels from the supply monitor pin are asynchronous
//
// Notes on behaviour
// R1: peak registers hold last interval's largest samples
// R2: apparent power is rms voltage times rms current
// R3: power factor is active over apparent, signed
// R4: temperature is signed with sixteen fraction bits
// R5: pulse sources follow channel select bit
// R6: write one clears flag only if condition gone
// R7: flag reaches interrupt only when mask set
// R8: data-ready on low-rate update, command, reset done
// R9: conversion-ready on every sample-rate update
// R10: instantaneous overflow sets per-channel range flags
// R11: rms overflow sets per-channel rms range flags
// R12: active power overflow sets energy range flag
// R13: current fault and voltage dip flags per channel
// R14: temperature update sets its flag
// R15: frequency ratio update sets its flag
// R16: modulator oscillation flagged per converter
// R17: low supply flag held until high threshold
// R18: bad-command bit normally one, zero on error
// R19: flags reset to one, mask resets to zero
// R20: control bits 23:16 give channel-2 phase delay
// R21: gain bits choose 250mV or 50mV range
// R22: stop bit write one ends memory sequence
// R23: open-drain irq, clock output, oscillator disables
// R24: irq level or pulse, either polarity
// R25: in level mode irq held while any flag and mask pair set
`timescale 1ns/10ps
`include "mrs_defines.svh"

module mrs_regs (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register access from the serial command engine
  input wire logic [`MRS_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [`MRS_W-1:0] reg_wdata,
  input wire logic reg_rd,
  output logic [`MRS_W-1:0] reg_rdata,
  // sample-rate results
  input wire logic sample_valid,
  input wire logic [`MRS_W-1:0] current1_sample,
  input wire logic [`MRS_W-1:0] voltage1_sample,
  input wire logic [`MRS_W-1:0] current2_sample,
  input wire logic [`MRS_W-1:0] voltage2_sample,
  // low-rate results
  input wire logic lowrate_valid,
  input wire logic [`MRS_W-1:0] voltage1_rms,
  input wire logic [`MRS_W-1:0] current1_rms,
  input wire logic [`MRS_W-1:0] voltage2_rms,
  input wire logic [`MRS_W-1:0] current2_rms,
  input wire logic [`MRS_W-1:0] active_power1,
  input wire logic [`MRS_W-1:0] active_power2,
  input wire logic [`MRS_W-1:0] reactive_power1,
  input wire logic [`MRS_W-1:0] reactive_power2,
  input wire logic pulse_channel_select,
  // temperature and line frequency
  input wire logic temperature_valid,
  input wire logic [`MRS_W-1:0] temperature_value,
  input wire logic frequency_valid,
  // command sequencer events
  input wire logic command_done,
  input wire logic reset_sequence_done,
  input wire logic bad_command,
  // datapath condition levels, index 0 is channel 1
  input wire logic [1:0] current_overflow,
  input wire logic [1:0] voltage_overflow,
  input wire logic [1:0] current_rms_overflow,
  input wire logic [1:0] voltage_rms_overflow,
  input wire logic [1:0] energy_overflow,
  input wire logic [1:0] current_fault,
  input wire logic [1:0] voltage_dip,
  // modulator oscillation: 0 current1, 1 voltage, 2 current2, 3 temperature
  input wire logic [3:0] modulator_osc,
  // supply monitor comparators on the monitor pin
  input wire logic power_fail_monitor_input_below_low,
  input wire logic power_fail_monitor_input_above_high,
  // interrupt configuration from the configuration register
  input wire logic irq_pulse_select,
  input wire logic irq_polarity_select,
  // interrupt pin
  output logic irq_pin_out,
  output logic irq_pin_oe,
  // control outputs
  output logic [7:0] phase_delay_ch2,
  output logic current1_range_select,
  output logic current2_range_select,
  output logic serial_mem_stop,
  output logic irq_open_drain,
  output logic host_clock_disable,
  output logic crystal_osc_disable
);

  ////////////////////////////////////////////////////////////////////////////
  // register storage

  logic [`MRS_W-1:0] event_flags;
  logic [`MRS_W-1:0] interrupt_enable_bits;
  logic [`MRS_W-1:0] control_bits;
  logic [`MRS_W-1:0] peak_reg [0:3];
  logic [`MRS_W-1:0] peak_run [0:3];
  logic [`MRS_W-1:0] apparent_power_ch1;
  logic [`MRS_W-1:0] apparent_power_ch2;
  logic [`MRS_W-1:0] power_factor_ch1;
  logic [`MRS_W-1:0] power_factor_ch2;
  logic [`MRS_W-1:0] die_temperature;
  logic [`MRS_W-1:0] active_pulse_source;
  logic [`MRS_W-1:0] apparent_pulse_source;
  logic [`MRS_W-1:0] reactive_pulse_source;
  logic [`MRS_W-1:0] flags_view;
  logic [`MRS_W-1:0] flag_set;
  logic [`MRS_W-1:0] flag_cond;
  logic [`MRS_W-1:0] samples [0:3];
  logic [`MRS_W-1:0] next_s1;
  logic [`MRS_W-1:0] next_s2;
  logic [47:0] prod1;
  logic [47:0] prod2;
  logic wr_flags;
  logic wr_mask;
  logic wr_ctrl;

  assign wr_flags = reg_wr && (reg_addr == `MRS_OFF_FLAGS);
  assign wr_mask = reg_wr && (reg_addr == `MRS_OFF_MASK);
  assign wr_ctrl = reg_wr && (reg_addr == `MRS_OFF_CTRL);

  // the bad-command bit is kept as an active-high error and read inverted
  assign flags_view = event_flags ^ `MRS_FLAGS_INV; // R18

  ////////////////////////////////////////////////////////////////////////////
  // supply monitor synchronisers and hysteresis

  logic [1:0] low_sync;
  logic [1:0] high_sync;
  logic low_supply_state;
  logic low_supply_prev;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      low_sync <= 2'h0;
      high_sync <= 2'h0;
    end else begin
      low_sync <= {low_sync[0], power_fail_monitor_input_below_low};
      high_sync <= {high_sync[0], power_fail_monitor_input_above_high};
    end
  end

  // the state stays low-supply until the high comparator trips
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      low_supply_state <= 1'b0;
      low_supply_prev <= 1'b0;
    end else begin
      low_supply_prev <= low_supply_state;
      if (low_sync[1]) begin
        low_supply_state <= 1'b1; // R17
      end else if (high_sync[1]) begin
        low_supply_state <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag set and hold conditions

  always_comb begin
    flag_set = `MRS_ZERO24;
    flag_cond = `MRS_ZERO24;
    flag_set[`MRS_B_LOWRATE_RESULTS_READY] = lowrate_valid || command_done || reset_sequence_done; // R8
    flag_set[`MRS_B_SAMPLE_RESULTS_READY] = sample_valid; // R9
    flag_set[`MRS_B_CURRENT1_OVERFLOW_FLAG] = current_overflow[0]; // R10
    flag_set[`MRS_B_CURRENT2_OVERFLOW_FLAG] = current_overflow[1];
    flag_set[`MRS_B_VOLTAGE1_OVERFLOW_FLAG] = voltage_overflow[0];
    flag_set[`MRS_B_VOLTAGE2_OVERFLOW_FLAG] = voltage_overflow[1];
    flag_set[`MRS_B_CURRENT1_RMS_OVERFLOW_FLAG] = current_rms_overflow[0]; // R11
    flag_set[`MRS_B_CURRENT2_RMS_OVERFLOW_FLAG] = current_rms_overflow[1];
    flag_set[`MRS_B_VOLTAGE1_RMS_OVERFLOW_FLAG] = voltage_rms_overflow[0];
    flag_set[`MRS_B_VOLTAGE2_RMS_OVERFLOW_FLAG] = voltage_rms_overflow[1];
    flag_set[`MRS_B_ENERGY1_OVERFLOW_FLAG] = energy_overflow[0]; // R12
    flag_set[`MRS_B_ENERGY2_OVERFLOW_FLAG] = energy_overflow[1];
    flag_set[`MRS_B_I1FLT] = current_fault[0]; // R13
    flag_set[`MRS_B_I2FLT] = current_fault[1];
    flag_set[`MRS_B_V1DIP] = voltage_dip[0];
    flag_set[`MRS_B_V2DIP] = voltage_dip[1];
    flag_set[`MRS_B_TUP] = temperature_valid; // R14
    flag_set[`MRS_B_FUP] = frequency_valid; // R15
    flag_set[`MRS_B_CURRENT1_MODULATOR_OSC_FLAG] = modulator_osc[0]; // R16
    flag_set[`MRS_B_VOD] = modulator_osc[1];
    flag_set[`MRS_B_CURRENT2_MODULATOR_OSC_FLAG] = modulator_osc[2];
    flag_set[`MRS_B_TOD] = modulator_osc[3];
    flag_set[`MRS_B_LSD] = low_supply_state && !low_supply_prev; // R17
    flag_set[`MRS_B_IC] = bad_command; // R18
    // a condition still present blocks the clear
    flag_cond = flag_set;
    flag_cond[`MRS_B_LSD] = low_supply_state; // R17
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky flags, one per bit; set wins over a same-cycle clear

  genvar fb;
  generate
    for (fb = 0; fb < `MRS_W; fb = fb + 1) begin : g_flag
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          event_flags[fb] <= 1'b0; // R19
        end else if (flag_set[fb]) begin
          event_flags[fb] <= 1'b1;
        end else if (wr_flags && reg_wdata[fb] && !flag_cond[fb]) begin
          event_flags[fb] <= 1'b0; // R6
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // mask and control registers

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_enable_bits <= `MRS_MASK_RST; // R19
    end else if (wr_mask) begin
      interrupt_enable_bits <= reg_wdata;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      control_bits <= `MRS_CTRL_RST;
    end else if (wr_ctrl) begin
      control_bits <= reg_wdata & `MRS_CTRL_KEEP;
    end
  end

  // stop is a strobe; writing 0 does nothing
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      serial_mem_stop <= 1'b0;
    end else begin
      serial_mem_stop <= wr_ctrl && reg_wdata[`MRS_C_STOP]; // R22
    end
  end

  assign phase_delay_ch2 = control_bits[`MRS_C_PC_HI:`MRS_C_PC_LO]; // R20
  assign current1_range_select = control_bits[`MRS_C_CURRENT1_RANGE_SELECT]; // R21
  assign current2_range_select = control_bits[`MRS_C_CURRENT2_RANGE_SELECT]; // R21
  assign irq_open_drain = control_bits[`MRS_C_IRQ_OPEN_DRAIN]; // R23
  assign host_clock_disable = control_bits[`MRS_C_HOST_CLOCK_DISABLE]; // R23
  assign crystal_osc_disable = control_bits[`MRS_C_CRYSTAL_OSC_DISABLE]; // R23

  ////////////////////////////////////////////////////////////////////////////
  // peak detection: 0 current1, 1 voltage1, 2 current2, 3 voltage2

  assign samples[0] = current1_sample;
  assign samples[1] = voltage1_sample;
  assign samples[2] = current2_sample;
  assign samples[3] = voltage2_sample;

  function automatic logic [`MRS_W-1:0] mag(input logic [`MRS_W-1:0] v);
    mag = v[`MRS_W-1] ? (~v + 24'h000001) : v;
  endfunction

  genvar pc;
  generate
    for (pc = 0; pc < 4; pc = pc + 1) begin : g_peak
      logic [`MRS_W-1:0] cand;
      // a sample arriving with the interval end counts in the interval that ends
      always_comb begin
        cand = peak_run[pc];
        if (sample_valid && (mag(samples[pc]) > mag(peak_run[pc]))) begin
          cand = samples[pc];
        end
      end
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          peak_run[pc] <= `MRS_ZERO24;
          peak_reg[pc] <= `MRS_ZERO24;
        end else if (lowrate_valid) begin
          peak_reg[pc] <= cand; // R1
          peak_run[pc] <= `MRS_ZERO24;
        end else begin
          peak_run[pc] <= cand;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // apparent power and power factor

  // rms inputs are 0.24 unsigned; the result is a sign-zero 1.23 fraction
  assign prod1 = voltage1_rms * current1_rms;
  assign prod2 = voltage2_rms * current2_rms;
  assign next_s1 = {1'b0, prod1[47:25]}; // R2
  assign next_s2 = {1'b0, prod2[47:25]}; // R2

  // a wide divide keeps the result in one cycle at the cost of area
  function automatic logic [`MRS_W-1:0] pfactor(input logic [`MRS_W-1:0] p,
                                               input logic [`MRS_W-1:0] s);
    logic [46:0] num;
    logic [46:0] quo;
    logic [`MRS_W-1:0] pm;
    num = 47'h0;
    quo = 47'h0;
    pm = mag(p);
    num = {pm, 23'h000000};
    pfactor = `MRS_ZERO24;
    if (s != `MRS_ZERO24) begin
      quo = num / {23'h000000, s};
      if (quo >= {23'h000000, `MRS_PF_MIN}) begin
        pfactor = p[`MRS_W-1] ? `MRS_PF_MIN : `MRS_PF_MAX;
      end else if (p[`MRS_W-1]) begin
        pfactor = ~quo[`MRS_W-1:0] + 24'h000001;
      end else begin
        pfactor = quo[`MRS_W-1:0];
      end
    end
  endfunction

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      apparent_power_ch1 <= `MRS_ZERO24;
      apparent_power_ch2 <= `MRS_ZERO24;
      power_factor_ch1 <= `MRS_ZERO24;
      power_factor_ch2 <= `MRS_ZERO24;
    end else if (lowrate_valid) begin
      apparent_power_ch1 <= next_s1;
      apparent_power_ch2 <= next_s2;
      power_factor_ch1 <= pfactor(active_power1, next_s1); // R3
      power_factor_ch2 <= pfactor(active_power2, next_s2); // R3
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pulse sources and temperature

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      active_pulse_source <= `MRS_ZERO24;
      apparent_pulse_source <= `MRS_ZERO24;
      reactive_pulse_source <= `MRS_ZERO24;
    end else if (lowrate_valid) begin
      active_pulse_source <= pulse_channel_select ? active_power2 : active_power1; // R5
      apparent_pulse_source <= pulse_channel_select ? next_s2 : next_s1; // R5
      reactive_pulse_source <= pulse_channel_select ? reactive_power2 : reactive_power1; // R5
    end
  end

  // signed 8.16 value in degrees, stored as delivered
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      die_temperature <= `MRS_ZERO24;
    end else if (temperature_valid) begin
      die_temperature <= temperature_value; // R4
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= `MRS_ZERO24;
    end else if (reg_rd) begin
      case (reg_addr)
        `MRS_OFF_FLAGS: reg_rdata <= flags_view;
        `MRS_OFF_I1PK: reg_rdata <= peak_reg[0];
        `MRS_OFF_V1PK: reg_rdata <= peak_reg[1];
        `MRS_OFF_S1: reg_rdata <= apparent_power_ch1;
        `MRS_OFF_PF1: reg_rdata <= power_factor_ch1;
        `MRS_OFF_I2PK: reg_rdata <= peak_reg[2];
        `MRS_OFF_V2PK: reg_rdata <= peak_reg[3];
        `MRS_OFF_S2: reg_rdata <= apparent_power_ch2;
        `MRS_OFF_PF2: reg_rdata <= power_factor_ch2;
        `MRS_OFF_MASK: reg_rdata <= interrupt_enable_bits;
        `MRS_OFF_TEMP: reg_rdata <= die_temperature;
        `MRS_OFF_CTRL: reg_rdata <= control_bits;
        `MRS_OFF_EPUL: reg_rdata <= active_pulse_source;
        `MRS_OFF_SPUL: reg_rdata <= apparent_pulse_source;
        `MRS_OFF_QPUL: reg_rdata <= reactive_pulse_source;
        default: reg_rdata <= `MRS_ZERO24;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt pin

  logic irq_active;
  logic irq_active_prev;
  logic irq_asserted;
  logic [`MRS_CNT_W-1:0] pulse_cnt;
  mrs_pkg::mrs_irq_state_t irq_state;

  assign irq_active = |(flags_view & interrupt_enable_bits); // R7 R25

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_active_prev <= 1'b0;
      irq_state <= mrs_pkg::MRS_IRQ_IDLE;
      pulse_cnt <= {`MRS_CNT_W{1'b0}};
    end else begin
      irq_active_prev <= irq_active;
      case (irq_state)
        mrs_pkg::MRS_IRQ_IDLE: begin
          if (irq_pulse_select && irq_active && !irq_active_prev) begin
            irq_state <= mrs_pkg::MRS_IRQ_PULSE; // R24
            pulse_cnt <= `MRS_CNT_W'(`MRS_IRQ_PULSE_CYC - 1);
          end
        end
        mrs_pkg::MRS_IRQ_PULSE: begin
          if (pulse_cnt == {`MRS_CNT_W{1'b0}}) begin
            irq_state <= mrs_pkg::MRS_IRQ_IDLE;
          end else begin
            pulse_cnt <= pulse_cnt - `MRS_CNT_W'(1);
          end
        end
        default: irq_state <= mrs_pkg::MRS_IRQ_IDLE;
      endcase
    end
  end

  assign irq_asserted = irq_pulse_select ? (irq_state == mrs_pkg::MRS_IRQ_PULSE)
                                         : irq_active; // R24 R25

  // open drain only pulls low, so the high level is released
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_pin_out <= 1'b1;
      irq_pin_oe <= 1'b1;
    end else begin
      irq_pin_out <= irq_polarity_select ? irq_asserted : !irq_asserted; // R24
      irq_pin_oe <= !irq_open_drain ||
                    !(irq_polarity_select ? irq_asserted : !irq_asserted); // R23
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  flag_set_wins_a: assert property (@(posedge clock) disable iff (sys_rst) // R6
    flag_set[`MRS_B_SAMPLE_RESULTS_READY] |=> event_flags[`MRS_B_SAMPLE_RESULTS_READY])
    else $error("flag set lost against clear");

  flag_clear_a: assert property (@(posedge clock) disable iff (sys_rst) // R6
    (wr_flags && reg_wdata[`MRS_B_LOWRATE_RESULTS_READY] && !flag_cond[`MRS_B_LOWRATE_RESULTS_READY])
    |=> !event_flags[`MRS_B_LOWRATE_RESULTS_READY])
    else $error("write one did not clear idle flag");

  flag_hold_a: assert property (@(posedge clock) disable iff (sys_rst) // R6
    (event_flags[`MRS_B_TUP] && !(wr_flags && reg_wdata[`MRS_B_TUP]))
    |=> event_flags[`MRS_B_TUP])
    else $error("flag dropped without a clear");

  mask_gate_a: assert property (@(posedge clock) disable iff (sys_rst) // R7
    (!irq_pulse_select && (interrupt_enable_bits == `MRS_ZERO24))
    |=> (irq_pin_out == !$past(irq_polarity_select)))
    else $error("interrupt without enabled flag");

  lsd_hold_a: assert property (@(posedge clock) disable iff (sys_rst) // R17
    (low_supply_state && !high_sync[1]) |=> low_supply_state)
    else $error("low supply released early");

  stop_pulse_a: assert property (@(posedge clock) disable iff (sys_rst) // R22
    (wr_ctrl && reg_wdata[`MRS_C_STOP]) |=> serial_mem_stop ##1
    (serial_mem_stop == $past(wr_ctrl && reg_wdata[`MRS_C_STOP])))
    else $error("stop strobe wrong");

  pulse_mux_a: assert property (@(posedge clock) disable iff (sys_rst) // R5
    (lowrate_valid && pulse_channel_select)
    |=> active_pulse_source == $past(active_power2))
    else $error("pulse source from wrong channel");

  pf_sign_a: assert property (@(posedge clock) disable iff (sys_rst) // R3
    (lowrate_valid && active_power1[`MRS_W-1] && (next_s1 != `MRS_ZERO24))
    |=> power_factor_ch1[`MRS_W-1] || (power_factor_ch1 == `MRS_ZERO24))
    else $error("power factor sign wrong");

  lowrate_results_ready_set_a: assert property (@(posedge clock) disable iff (sys_rst) // R8
    reset_sequence_done |=> flags_view[`MRS_B_LOWRATE_RESULTS_READY])
    else $error("data ready not set");

  ic_low_a: assert property (@(posedge clock) disable iff (sys_rst) // R18
    bad_command |=> !flags_view[`MRS_B_IC])
    else $error("bad command bit not driven low");

  pulse_len_a: assert property (@(posedge clock) disable iff (sys_rst) // R24
    (irq_state == mrs_pkg::MRS_IRQ_IDLE) ##1 (irq_state == mrs_pkg::MRS_IRQ_PULSE)
    |-> (irq_state == mrs_pkg::MRS_IRQ_PULSE) [*8])
    else $error("interrupt pulse too short");

endmodule

/* File: tb/mrs_host.sv */
// host side of the register port, one access at a time
// assumes requests are sampled on the rising clock edge
`timescale 1ns/10ps
`include "mrs_defines.svh"

module mrs_host (
  // clock
  input wire logic clock,
  // register port
  output logic [`MRS_AW-1:0] reg_addr,
  output logic reg_wr,
  output logic [`MRS_W-1:0] reg_wdata,
  output logic reg_rd,
  input wire logic [`MRS_W-1:0] reg_rdata
);
  initial begin
    {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
  end
  // released address and data lines show the inverse so stale values never pass for data; write and read strobes drop to 0
  task automatic acc(input logic w, input logic [4:0] a, input logic [23:0] d);
    @(posedge clock);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, d, w, ~w};
    @(posedge clock);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {~a, ~d, 2'b00};
  endtask
endmodule

/* File: tb/tb.sv */
// register bank bench: access table, then flag, result and irq cases
// assumes mrs_host owns the register port; all other inputs driven here
`timescale 1ns/10ps
`include "mrs_defines.svh"

module tb;
  logic clock, sys_rst, pcs, hi, reg_wr, reg_rd, stop, irq, oe, ps, pol;
  logic [4:0] reg_addr, cb;
  logic [23:0] reg_wdata, reg_rdata, smp, rms, p1, p2, q1, q2, tv;
  logic [25:0] ev;
  logic [7:0] pd;
  int errors, checks_done;
  byte fb[25] = '{20, 23, 7, 1, 23, 23, 0, 17, 22, 16, 21, 14, 19, 13, 18, 12, 15, 11, 9, 10,
    8, 3, 4, 5, 6};
  // bit 7 of the first byte marks a write before the read
  logic [55:0] rows[6] = '{56'h0f_000000_000001, 56'h1a_000000_000000, 56'h1c_000000_000000,
    56'h9a_abcdef_abcdef, 56'h83_123456_000000, 56'h9c_ff1136_ff1036};
  logic [31:0] res[12] = '{32'h12c00000, 32'h16c00000, 32'h13c00000, 32'h17c00000,
    32'h14200000, 32'h18200000,
    32'h15400000, 32'h19c00000, 32'h1b1a8000, 32'h1d100000, 32'h1e200000, 32'h1f654321};

  mrs_host host (.clock, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
  mrs_regs dut (.clock, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .sample_valid(ev[0]), .current1_sample(smp), .voltage1_sample(smp), .current2_sample(smp),
    .voltage2_sample(smp), .lowrate_valid(ev[1]), .voltage1_rms(rms), .current1_rms(rms),
    .voltage2_rms(rms), .current2_rms(rms), .active_power1(p1), .active_power2(p2),
    .reactive_power1(q1), .reactive_power2(q2), .pulse_channel_select(pcs),
    .temperature_valid(ev[2]), .temperature_value(tv), .frequency_valid(ev[3]),
    .command_done(ev[4]), .reset_sequence_done(ev[5]), .bad_command(ev[6]),
    .current_overflow(ev[8:7]), .voltage_overflow(ev[10:9]), .current_rms_overflow(ev[12:11]),
    .voltage_rms_overflow(ev[14:13]), .energy_overflow(ev[16:15]), .current_fault(ev[18:17]),
    .voltage_dip(ev[20:19]), .modulator_osc(ev[24:21]), .power_fail_monitor_input_below_low(ev[25]),
    .power_fail_monitor_input_above_high(hi), .irq_pulse_select(ps), .irq_polarity_select(pol),
    .irq_pin_out(irq), .irq_pin_oe(oe), .phase_delay_ch2(pd), .current1_range_select(cb[3]),
    .current2_range_select(cb[4]), .serial_mem_stop(stop), .irq_open_drain(cb[2]),
    .host_clock_disable(cb[1]), .crystal_osc_disable(cb[0]));

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [4:0] a, input logic [23:0] e);
    host.acc(1'b0, a, 24'h000000);
    #1 check(reg_rdata, e);
  endtask
  task automatic summarize;
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic pulse(input logic [25:0] v, input int n);
    ev <= v;
    @(posedge clock);
    ev <= 26'h0;
    repeat (n) @(posedge clock);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // run needs well under a thousand cycles
  initial begin
    #40000;
    errors++;
    summarize();
  end
  initial begin
    {sys_rst, hi, pcs, ps, pol, ev, smp} = {5'b11000, 26'h0, 24'h0};
    {rms, p1, p2, q1, q2, tv} = {24'h800000, 24'h100000, 24'hf00000, 24'h654321, 24'h123456,
      24'h1a8000};
    repeat (3) @(posedge clock);
    check({oe, irq}, 2'b11);
    sys_rst <= 1'b0;
    foreach (rows[k]) begin
      if (rows[k][55]) host.acc(1'b1, rows[k][52:48], rows[k][47:24]);
      rdchk(rows[k][52:48], rows[k][23:0]);
    end
    check({pd, cb}, 13'h1fff);
    host.acc(1'b1, `MRS_OFF_CTRL, 24'h000100);
    #1 check({stop, pd, cb}, 14'h2000);
    @(posedge clock);
    #1 check(stop, 1'b0);
    for (int j = 0; j < 25; j++) begin
      pulse(26'h1 << j, 0);
      rdchk(`MRS_OFF_FLAGS,
        j == 6 ? 24'h0 : 24'h1 | 24'h1 << fb[j]);
      host.acc(1'b1, `MRS_OFF_FLAGS, 24'hffffff);
    end
    pulse(26'h20000, 0);
    host.acc(1'b1, `MRS_OFF_FLAGS, 24'h0);
    rdchk(`MRS_OFF_FLAGS, 24'h000801);
    hi <= 1'b0;
    pulse(26'h2000000, 3);
    host.acc(1'b1, `MRS_OFF_FLAGS, 24'hffffff);
    rdchk(`MRS_OFF_FLAGS, 24'h000005);
    hi <= 1'b1;
    repeat (4) @(posedge clock);
    host.acc(1'b1, `MRS_OFF_FLAGS, 24'hffffff);
    rdchk(`MRS_OFF_FLAGS, 24'h000001);
    smp <= 24'hc00000;
    pulse(26'h1, 1);
    smp <= 24'h200000;
    pulse(26'h7, 0);
    foreach (res[k]) rdchk(res[k][28:24], res[k][23:0]);
    pcs <= 1'b1;
    pulse(26'h2, 0);
    rdchk(`MRS_OFF_EPUL, 24'hf00000);
    rdchk(`MRS_OFF_QPUL, 24'h123456);
    host.acc(1'b1, `MRS_OFF_FLAGS, 24'hffffff);
    host.acc(1'b1, `MRS_OFF_MASK, 24'h100000);
    pulse(26'h4, 3);
    #1 check({oe, irq}, 2'b11);
    pulse(26'h1, 3);
    #1 check({oe, irq}, 2'b10);
    host.acc(1'b1, `MRS_OFF_FLAGS, 24'h100000);
    repeat (2) @(posedge clock);
    #1 check({oe, irq}, 2'b11);
    // high-going pulse mode, open-drain pin released while high
    {ps, pol} <= 2'b11;
    host.acc(1'b1, `MRS_OFF_CTRL, 24'h000010);
    pulse(26'h1, 3);
    #1 check({oe, irq}, 2'b01);
    repeat (248) @(posedge clock);
    #1 check({oe, irq}, 2'b01);
    @(posedge clock);
    #1 check({oe, irq}, 2'b10);
    // reset in mid-run restores the defaults
    sys_rst <= 1'b1;
    @(posedge clock);
    sys_rst <= 1'b0;
    rdchk(`MRS_OFF_MASK, 24'h000000);
    rdchk(`MRS_OFF_FLAGS, 24'h000001);
    check({oe, irq}, 2'b10);
    summarize();
  end
endmodule
